//--- pkg/vmcsr_pkg.sv
// Offsets, field positions and reset values of the control/status bank
package vmcsr_pkg;
   localparam logic [15:0] OFF_SLOT = 16'h1002;
   localparam logic [15:0] OFF_CHAIN = 16'h1004;
   localparam logic [15:0] OFF_SET1 = 16'h1006;
   localparam logic [15:0] OFF_CLR1 = 16'h1008;
   localparam logic [15:0] OFF_LEVEL = 16'h100a;
   localparam logic [15:0] OFF_VECTOR = 16'h100c;
   localparam logic [15:0] OFF_STAT1 = 16'h100e;
   localparam logic [15:0] OFF_CTRL1 = 16'h1010;
   localparam logic [15:0] OFF_BASEH = 16'h1012;
   localparam logic [4:0] SLOT_RST = 5'h1f;
   localparam logic [7:0] CHAIN_RST = 8'haa;
   localparam logic [2:0] LEVEL_RST = 3'h0;
   localparam logic [7:0] VECTOR_RST = 8'h00;
   localparam logic [7:0] BASEH_RST = 8'h00;
   localparam int CG1_BERR = 3;
   localparam int CG1_SEL = 4;
   localparam int CG1_SRST = 7;
   localparam logic [7:0] CG1_MASK = 8'h98;
   localparam logic [7:0] CG1_RST = 8'h00;
   localparam int CR1_STOP = 2;
   localparam int CR1_SCOPE = 4;
   localparam int CR1_BERR_EN = 5;
   localparam int CR1_PAD = 6;
   localparam logic [7:0] CR1_MASK = 8'h74;
   localparam logic [7:0] CR1_RST = 8'h00;
   localparam int ST_DRDY = 0;
   localparam int ST_CRDY = 1;
   localparam int ST_BUSY = 2;
   localparam int ST_CBUSY = 3;
   localparam int ST_UNK = 4;
   localparam int ST_PURGED = 5;
   localparam int ST_EVENT_THRESHOLD_FLAG = 8;
endpackage : vmcsr_pkg

//--- rtl/vmcsr_top.sv
// Control and status register bank with reset and readout steering
`timescale 1ns/1ps
`default_nettype none

// ************
// Pin synchroniser
// ************
module vmcsr_sync #(parameter int W = 1) (
   input wire logic clk,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_q, s2_q, s3_q;
   wire [W-1:0] agree = ~(s2_q ^ s3_q);
   // No reset: reset must be held long enough to fill the chain
   always_ff @(posedge clk) begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q <= (s2_q & agree) | (q & ~agree);
   end
endmodule : vmcsr_sync

// ************
// Register bank
// ************
module vmcsr_top #(parameter int EV_W = 6) (
   input wire logic MCLK,
   input wire logic SYS_RST,
   input wire logic [15:0] REG_ADDR,
   input wire logic [15:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic REG_IACK,
   output logic [15:0] REG_RDATA,
   output logic REG_ACK,
   input wire logic AUX_PRESENT,
   input wire logic [4:0] SLOT_LINES,
   input wire logic [7:0] ROTARY_HIGH,
   input wire logic FRONT_RESET,
   input wire logic CHAIN_READY_LINE,
   input wire logic CHAIN_BUSY_LINE,
   input wire logic [EV_W-1:0] EVENT_COUNT,
   input wire logic [4:0] EVENT_TRIGGER,
   input wire logic CONV_ACTIVE,
   input wire logic BUF_FULL,
   input wire logic MEM_TEST,
   input wire logic BLT_START,
   input wire logic BLT_WORD,
   input wire logic WORD_IS_TRAILER,
   input wire logic WORD_IS_LAST,
   input wire logic WIDE32,
   input wire logic CHAIN_DONE,
   output logic [4:0] SLOT_NUMBER,
   output logic [7:0] CHAIN_ADDR,
   output logic [7:0] BASE_HIGH,
   output logic BASE_FROM_REGS,
   output logic [2:0] IRQ_LEVEL,
   output logic IRQ_REQ,
   output logic BERR_OUT,
   output logic SEND_INVALID,
   output logic PAD_REQ,
   output logic MODULE_RESET,
   output logic DATA_RESET
);
   // ************
   // Pin inputs
   // ************
   logic [16:0] pins_s;
   vmcsr_sync #(.W(17)) u_sync (
      .clk(MCLK),
      .d({AUX_PRESENT, SLOT_LINES, ROTARY_HIGH, FRONT_RESET,
          CHAIN_READY_LINE, CHAIN_BUSY_LINE}),
      .q(pins_s)
   );
   wire aux_s = pins_s[16];
   wire [4:0] slot_s = pins_s[15:11];
   wire [7:0] rot_s = pins_s[10:3];
   wire front_s = pins_s[2];
   wire crdy_s = pins_s[1];
   wire cbusy_s = pins_s[0];

   // ************
   // State
   // ************
   logic [4:0] slot_wr_q, slot_act_q;
   logic [7:0] chain_q, cg1_q, cr1_q, vector_q, baseh_q, base_o_q;
   logic [2:0] level_q;
   logic [15:0] rdata_q;
   logic unk_q, irq_q, purged_q, inval_q, parity_q, front_prev_q;
   logic ack_q, mrst_q, dres_q, berr_o_q, pad_q, sel_o_q;

   // ************
   // Decode
   // ************
   wire hit_slot = REG_ADDR == vmcsr_pkg::OFF_SLOT;
   wire hit_chain = REG_ADDR == vmcsr_pkg::OFF_CHAIN;
   wire hit_set = REG_ADDR == vmcsr_pkg::OFF_SET1;
   wire hit_clr = REG_ADDR == vmcsr_pkg::OFF_CLR1;
   wire hit_lvl = REG_ADDR == vmcsr_pkg::OFF_LEVEL;
   wire hit_vec = REG_ADDR == vmcsr_pkg::OFF_VECTOR;
   wire hit_st = REG_ADDR == vmcsr_pkg::OFF_STAT1;
   wire hit_ctl = REG_ADDR == vmcsr_pkg::OFF_CTRL1;
   wire hit_bh = REG_ADDR == vmcsr_pkg::OFF_BASEH;
   wire [7:0] set_w = (REG_WR && hit_set) ?
      (REG_WDATA[7:0] & vmcsr_pkg::CG1_MASK) : 8'h00;
   wire [7:0] clr_w = (REG_WR && hit_clr) ?
      (REG_WDATA[7:0] & vmcsr_pkg::CG1_MASK) : 8'h00;

   // ************
   // Resets
   // ************
   wire front_rise = front_s & ~front_prev_q;
   wire front_soft = front_rise & cr1_q[vmcsr_pkg::CR1_SCOPE];
   wire front_data = front_rise & ~cr1_q[vmcsr_pkg::CR1_SCOPE];
   wire soft_now = cg1_q[vmcsr_pkg::CG1_SRST] | front_soft;
   wire any_rst = SYS_RST | soft_now;

   // ************
   // Block transfer steering
   // ************
   wire stop_m = cr1_q[vmcsr_pkg::CR1_STOP];
   wire berr_evt = BLT_WORD & cr1_q[vmcsr_pkg::CR1_BERR_EN] &
      (stop_m ? WORD_IS_TRAILER : WORD_IS_LAST);
   wire inval_set = BLT_WORD & (WORD_IS_LAST | (stop_m & WORD_IS_TRAILER));
   wire pad_evt = BLT_WORD & WORD_IS_TRAILER & ~parity_q & WIDE32 &
      cr1_q[vmcsr_pkg::CR1_PAD];

   // ************
   // Interrupt and status
   // ************
   wire [EV_W-1:0] trig_w = EV_W'(EVENT_TRIGGER);
   wire irq_set = (EVENT_COUNT == trig_w) && (EVENT_TRIGGER != 5'h00) &&
      (level_q != 3'h0);
   wire irq_d = irq_set | (irq_q & ~REG_IACK & (level_q != 3'h0));
   wire event_threshold_flag_w = (trig_w >= EVENT_COUNT) & irq_q;
   wire busy_w = CONV_ACTIVE | mrst_q | BUF_FULL | MEM_TEST;
   logic [15:0] st1_w;
   always_comb begin
      st1_w = 16'h0000;
      st1_w[vmcsr_pkg::ST_DRDY] = EVENT_COUNT != '0;
      st1_w[vmcsr_pkg::ST_CRDY] = crdy_s | (EVENT_COUNT != '0);
      st1_w[vmcsr_pkg::ST_BUSY] = busy_w;
      st1_w[vmcsr_pkg::ST_CBUSY] = cbusy_s | busy_w;
      st1_w[vmcsr_pkg::ST_UNK] = unk_q;
      st1_w[vmcsr_pkg::ST_PURGED] = purged_q;
      st1_w[vmcsr_pkg::ST_EVENT_THRESHOLD_FLAG] = event_threshold_flag_w;
   end

   // ************
   // Read path
   // ************
   // Zero upper bits, except bit 8 of the status word
   wire [15:0] rd_w =
      hit_slot ? {11'h000, aux_s ? slot_act_q : slot_wr_q} :
      hit_chain ? {8'h00, chain_q} :
      (hit_set | hit_clr) ? {8'h00, cg1_q} :
      hit_lvl ? {13'h0000, level_q} :
      hit_vec ? {8'h00, vector_q} :
      hit_st ? st1_w :
      hit_ctl ? {8'h00, cr1_q} :
      hit_bh ? {8'h00, baseh_q} : 16'h0000;
   wire ack_d = (REG_WR & ~(hit_slot & aux_s)) | REG_RD | REG_IACK;

   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         rdata_q <= 16'h0000;
         ack_q <= 1'b0;
      end else begin
         ack_q <= ack_d;
         if (REG_IACK) begin
            rdata_q <= {8'h00, vector_q};
         end else if (REG_RD) begin
            rdata_q <= rd_w;
         end
      end
   end

   // ************
   // Slot number and plain registers
   // ************
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         slot_wr_q <= vmcsr_pkg::SLOT_RST;
      end else if (REG_WR && hit_slot && !aux_s) begin
         slot_wr_q <= REG_WDATA[4:0];
      end
   end
   always_ff @(posedge MCLK) begin
      if (any_rst) begin
         slot_act_q <= aux_s ? slot_s : slot_wr_q;
         unk_q <= ~aux_s;
      end
   end
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         chain_q <= vmcsr_pkg::CHAIN_RST;
         level_q <= vmcsr_pkg::LEVEL_RST;
         vector_q <= vmcsr_pkg::VECTOR_RST;
         baseh_q <= vmcsr_pkg::BASEH_RST;
      end else if (REG_WR) begin
         if (hit_chain) begin
            chain_q <= REG_WDATA[7:0];
         end
         if (hit_lvl) begin
            level_q <= REG_WDATA[2:0];
         end
         if (hit_vec) begin
            vector_q <= REG_WDATA[7:0];
         end
         if (hit_bh) begin
            baseh_q <= REG_WDATA[7:0];
         end
      end
   end

   // ************
   // Control group 1 and control 1
   // ************
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         cg1_q <= vmcsr_pkg::CG1_RST;
      end else begin
         cg1_q <= (cg1_q | set_w) & ~clr_w;
         cg1_q[vmcsr_pkg::CG1_BERR] <= berr_evt |
            set_w[vmcsr_pkg::CG1_BERR] |
            (cg1_q[vmcsr_pkg::CG1_BERR] & ~clr_w[vmcsr_pkg::CG1_BERR] &
             ~soft_now);
      end
   end
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         cr1_q <= vmcsr_pkg::CR1_RST;
      end else if (soft_now) begin
         cr1_q <= cr1_q & (8'h01 << vmcsr_pkg::CR1_SCOPE);
      end else if (REG_WR && hit_ctl) begin
         cr1_q <= REG_WDATA[7:0] & vmcsr_pkg::CR1_MASK;
      end
   end

   // ************
   // Event flags
   // ************
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         irq_q <= 1'b0;
         purged_q <= 1'b0;
         inval_q <= 1'b0;
         parity_q <= 1'b0;
         front_prev_q <= 1'b0;
      end else begin
         front_prev_q <= front_s;
         irq_q <= irq_d;
         purged_q <= CHAIN_DONE | (purged_q & ~BLT_START & ~soft_now);
         inval_q <= inval_set | (inval_q & ~BLT_START);
         if (BLT_START || (BLT_WORD && WORD_IS_TRAILER)) begin
            parity_q <= 1'b0;
         end else if (BLT_WORD) begin
            parity_q <= ~parity_q;
         end
      end
   end

   // ************
   // Outputs
   // ************
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         mrst_q <= 1'b1;
         dres_q <= 1'b0;
         berr_o_q <= 1'b0;
         pad_q <= 1'b0;
         base_o_q <= 8'h00;
         sel_o_q <= 1'b0;
      end else begin
         mrst_q <= soft_now;
         dres_q <= front_data;
         berr_o_q <= berr_evt;
         pad_q <= pad_evt;
         sel_o_q <= cg1_q[vmcsr_pkg::CG1_SEL];
         base_o_q <= cg1_q[vmcsr_pkg::CG1_SEL] ? baseh_q : rot_s;
      end
   end

   assign REG_RDATA = rdata_q;
   assign REG_ACK = ack_q;
   assign SLOT_NUMBER = slot_act_q;
   assign CHAIN_ADDR = chain_q;
   assign BASE_HIGH = base_o_q;
   assign BASE_FROM_REGS = sel_o_q;
   assign IRQ_LEVEL = level_q;
   assign IRQ_REQ = irq_q;
   assign BERR_OUT = berr_o_q;
   assign SEND_INVALID = inval_q;
   assign PAD_REQ = pad_q;
   assign MODULE_RESET = mrst_q;
   assign DATA_RESET = dres_q;

   // ************
   // Checks
   // ************
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (SYS_RST);
   property p_slot_noack;
      REG_WR && hit_slot && aux_s && !REG_RD && !REG_IACK |=> !REG_ACK;
   endproperty
   a_slot_noack: assert property (p_slot_noack)
      else $error("slot write acknowledged with aux present");
   property p_chain_rst;
      $past(SYS_RST) |-> CHAIN_ADDR == 8'haa;
   endproperty
   a_chain_rst: assert property (p_chain_rst)
      else $error("chain address not at default after reset");
   property p_set;
      REG_WR && hit_set && REG_WDATA[4] |=> cg1_q[4] ##1 cg1_q[4] || $past(clr_w[4]);
   endproperty
   a_set: assert property (p_set)
      else $error("set register failed to set bit");
   property p_clr;
      REG_WR && hit_clr && REG_WDATA[4] |=> !cg1_q[4];
   endproperty
   a_clr: assert property (p_clr)
      else $error("clear register failed to clear bit");
   property p_hold;
      cg1_q[7] |=> MODULE_RESET;
   endproperty
   a_hold: assert property (p_hold)
      else $error("module reset not held");
   property p_soft_berr;
      soft_now && !berr_evt && !set_w[3] |=> !cg1_q[3];
   endproperty
   a_soft_berr: assert property (p_soft_berr)
      else $error("bus error flag survived soft reset");
   property p_scope;
      soft_now |=> cr1_q[4] == $past(cr1_q[4]) && cr1_q[5] == 1'b0;
   endproperty
   a_scope: assert property (p_scope)
      else $error("soft reset handled control bits wrongly");
   property p_irq;
      irq_set |=> IRQ_REQ;
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt not raised on trigger match");
   property p_lvl0;
      level_q == 3'h0 |=> !IRQ_REQ;
   endproperty
   a_lvl0: assert property (p_lvl0)
      else $error("interrupt raised at level zero");
   property p_vec;
      REG_IACK |=> REG_ACK && REG_RDATA == {8'h00, $past(vector_q)};
   endproperty
   a_vec: assert property (p_vec)
      else $error("vector not returned on acknowledge");
   property p_berr;
      berr_evt |=> BERR_OUT && cg1_q[3];
   endproperty
   a_berr: assert property (p_berr)
      else $error("bus error not issued or flagged");
   property p_base;
      !$past(SYS_RST) |-> BASE_HIGH == ($past(cg1_q[4]) ? $past(baseh_q) : $past(rot_s));
   endproperty
   a_base: assert property (p_base)
      else $error("base address source wrong");
endmodule : vmcsr_top

`default_nettype wire

//--- dv/vmcsr_master.sv
// Bus master model that reaches the control/status bank
`timescale 1ns/1ps
`default_nettype none

// ************
// Master model
// ************
module vmcsr_master (
   input wire logic clk,
   input wire logic ack,
   input wire logic [15:0] rdata,
   output logic [15:0] addr,
   output logic [15:0] wdata,
   output logic wr,
   output logic rd,
   output logic iack
);
   initial begin
      addr = 16'h0000;
      wdata = 16'h0000;
      wr = 1'b0;
      rd = 1'b0;
      iack = 1'b0;
   end

   // Kind 0 write, 1 read, 2 interrupt acknowledge
   task automatic xfer(input int kind, input logic [15:0] a, input logic [15:0] d,
                       output logic [15:0] q, output logic got);
      got = 1'b0;
      q = 16'h0000;
      @(negedge clk);
      addr = a;
      wdata = d;
      wr = (kind == 0);
      rd = (kind == 1);
      iack = (kind == 2);
      for (int i = 0; i < 6 && !got; i++) begin
         @(negedge clk);
         wr = 1'b0;
         rd = 1'b0;
         iack = 1'b0;
         if (ack === 1'b1) begin
            got = 1'b1;
            q = rdata;
         end
      end
      // Released lines carry no stale value
      addr = ~a;
      wdata = ~d;
   endtask : xfer
endmodule : vmcsr_master
`default_nettype wire

//--- dv/vmcsr_top_tb.sv
// Self-checking bench for the control/status register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; $display("[FAIL] %s expected %h seen %h", n, e, g); end end

module vmcsr_top_tb;
   logic mclk, sys_rst, wr, rd, iack, ack, aux, front, crdy, cbusy, conv, full, mtest;
   logic bstart, bword, trl, last, wide, cdone, base_sel, irq, berr, inval, pad, mrst, drst;
   logic [15:0] addr, wdata, rdata, q;
   logic [4:0] slot_lines, trig, slot;
   logic [7:0] rotary, chain, base;
   logic [5:0] evc;
   logic [2:0] lvl;
   logic got;
   int failures = 0;
   int samples_checked = 0;
   int berr_n = 0;
   int pad_n = 0;
   int drst_n = 0;

   vmcsr_top #(.EV_W(6)) u_dut (.MCLK(mclk), .SYS_RST(sys_rst), .REG_ADDR(addr),
      .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_IACK(iack), .REG_RDATA(rdata),
      .REG_ACK(ack), .AUX_PRESENT(aux), .SLOT_LINES(slot_lines), .ROTARY_HIGH(rotary),
      .FRONT_RESET(front), .CHAIN_READY_LINE(crdy), .CHAIN_BUSY_LINE(cbusy),
      .EVENT_COUNT(evc), .EVENT_TRIGGER(trig), .CONV_ACTIVE(conv), .BUF_FULL(full),
      .MEM_TEST(mtest), .BLT_START(bstart), .BLT_WORD(bword), .WORD_IS_TRAILER(trl),
      .WORD_IS_LAST(last), .WIDE32(wide), .CHAIN_DONE(cdone), .SLOT_NUMBER(slot),
      .CHAIN_ADDR(chain), .BASE_HIGH(base), .BASE_FROM_REGS(base_sel), .IRQ_LEVEL(lvl),
      .IRQ_REQ(irq), .BERR_OUT(berr), .SEND_INVALID(inval), .PAD_REQ(pad),
      .MODULE_RESET(mrst), .DATA_RESET(drst));

   vmcsr_master u_mst (.clk(mclk), .ack(ack), .rdata(rdata), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .iack(iack));

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // Count one-cycle pulses from the readout steering and the data reset
   always @(posedge mclk) begin
      if (berr === 1'b1) berr_n++;
      if (pad === 1'b1) pad_n++;
      if (drst === 1'b1) drst_n++;
   end

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : tally_and_finish

   task automatic wreg(input logic [15:0] a, input logic [15:0] d);
      u_mst.xfer(0, a, d, q, got);
      `CHK("write ack", 1'b1, got)
   endtask : wreg

   task automatic rchk(input string n, input logic [15:0] a, input logic [15:0] e);
      u_mst.xfer(1, a, 16'h0000, q, got);
      `CHK(n, 1'b1, got)
      `CHK(n, e, q)
   endtask : rchk

   task automatic hard_reset();
      @(negedge mclk);
      sys_rst = 1'b1;
      repeat (5) @(negedge mclk);
      sys_rst = 1'b0;
      @(negedge mclk);
   endtask : hard_reset

   task automatic word(input logic t, input logic l);
      @(negedge mclk);
      bword = 1'b1;
      trl = t;
      last = l;
      @(negedge mclk);
      bword = 1'b0;
      trl = 1'b0;
      last = 1'b0;
   endtask : word

   task automatic blt_begin();
      @(negedge mclk);
      bstart = 1'b1;
      @(negedge mclk);
      bstart = 1'b0;
   endtask : blt_begin

   task automatic t_reset();
      rchk("chain", 16'h1004, {8'h00, vmcsr_pkg::CHAIN_RST});
      rchk("level", 16'h100a, 16'h0000);
      rchk("vector", 16'h100c, 16'h0000);
      rchk("group1", 16'h1006, 16'h0000);
      rchk("slot reg", 16'h1002, {11'h000, vmcsr_pkg::SLOT_RST});
      rchk("status", 16'h100e, 16'h0010);
      rchk("unmapped", 16'h1030, 16'h0000);
   endtask : t_reset

   task automatic t_setclr();
      wreg(16'h1012, 16'h0037);
      `CHK("rotary base", 8'hc3, base)
      wreg(16'h1006, 16'h0010);
      wreg(16'h1006, 16'h0008);
      rchk("set", 16'h1006, 16'h0018);
      `CHK("base select", 1'b1, base_sel)
      `CHK("reg base", 8'h37, base)
      wreg(16'h1008, 16'h0008);
      rchk("clear", 16'h1008, 16'h0010);
      wreg(16'h1006, 16'h0067);
      rchk("loose bits", 16'h1006, 16'h0010);
      wreg(16'h1006, 16'h0088);
      rchk("soft hold", 16'h1006, 16'h0090);
      `CHK("held", 1'b1, mrst)
      wreg(16'h1008, 16'h0080);
      repeat (2) @(negedge mclk);
      `CHK("released", 1'b0, mrst)
      wreg(16'h1008, 16'h0010);
   endtask : t_setclr

   task automatic t_slot();
      wreg(16'h1002, 16'h0005);
      `CHK("slot before reset", 5'h1f, slot)
      rchk("slot reg", 16'h1002, 16'h0005);
      // Master resets after writing the slot number
      wreg(16'h1006, 16'h0080);
      wreg(16'h1008, 16'h0080);
      repeat (2) @(negedge mclk);
      `CHK("slot after reset", 5'h05, slot)
      aux = 1'b1;
      slot_lines = 5'h0b;
      hard_reset();
      `CHK("slot lines", 5'h0b, slot)
      rchk("status aux", 16'h100e, 16'h0000);
      u_mst.xfer(0, 16'h1002, 16'h0003, q, got);
      `CHK("slot write ack", 1'b0, got)
      aux = 1'b0;
      hard_reset();
      `CHK("slot default", 5'h1f, slot)
   endtask : t_slot

   task automatic t_status();
      evc = 6'h01;
      repeat (4) @(negedge mclk);
      rchk("ready", 16'h100e, 16'h0013);
      evc = 6'h00;
      crdy = 1'b1;
      repeat (4) @(negedge mclk);
      rchk("chain ready", 16'h100e, 16'h0012);
      crdy = 1'b0;
      for (int i = 0; i < 3; i++) begin
         {conv, full, mtest} = 3'h4 >> i;
         repeat (4) @(negedge mclk);
         rchk("busy", 16'h100e, 16'h001c);
      end
      {conv, full, mtest} = 3'h0;
      cbusy = 1'b1;
      repeat (4) @(negedge mclk);
      rchk("chain busy", 16'h100e, 16'h0018);
      cbusy = 1'b0;
   endtask : t_status

   task automatic t_irq();
      wreg(16'h100a, 16'h0002);
      wreg(16'h100c, 16'h00a5);
      `CHK("level out", 3'h2, lvl)
      trig = 5'h03;
      evc = 6'h03;
      for (int i = 0; i < 8 && irq !== 1'b1; i++) @(negedge mclk);
      `CHK("irq raised", 1'b1, irq)
      if (irq !== 1'b1) tally_and_finish();
      rchk("threshold", 16'h100e, 16'h0113);
      evc = 6'h00;
      u_mst.xfer(2, 16'h0000, 16'h0000, q, got);
      `CHK("iack vector", 16'h00a5, q)
      `CHK("irq cleared", 1'b0, irq)
      wreg(16'h100a, 16'h0000);
      evc = 6'h03;
      repeat (4) @(negedge mclk);
      `CHK("level zero", 1'b0, irq)
      evc = 6'h00;
      trig = 5'h00;
   endtask : t_irq

   task automatic t_readout();
      berr_n = 0;
      wreg(16'h1010, 16'h0024);
      blt_begin();
      word(1'b0, 1'b0);
      word(1'b1, 1'b0);
      repeat (2) @(negedge mclk);
      `CHK("berr at trailer", 1, berr_n)
      `CHK("invalid after trailer", 1'b1, inval)
      rchk("bus flag", 16'h1006, 16'h0008);
      berr_n = 0;
      wreg(16'h1010, 16'h0020);
      blt_begin();
      `CHK("valid again", 1'b0, inval)
      word(1'b0, 1'b0);
      word(1'b1, 1'b0);
      word(1'b0, 1'b1);
      repeat (2) @(negedge mclk);
      `CHK("berr at last", 1, berr_n)
      `CHK("invalid after last", 1'b1, inval)
      pad_n = 0;
      wreg(16'h1010, 16'h0040);
      wide = 1'b1;
      blt_begin();
      word(1'b0, 1'b0);
      word(1'b0, 1'b0);
      word(1'b1, 1'b0);
      word(1'b0, 1'b0);
      word(1'b1, 1'b0);
      repeat (2) @(negedge mclk);
      `CHK("pad odd only", 1, pad_n)
      wide = 1'b0;
      @(negedge mclk);
      cdone = 1'b1;
      @(negedge mclk);
      cdone = 1'b0;
      rchk("purged", 16'h100e, 16'h0030);
      wreg(16'h1008, 16'h0008);
   endtask : t_readout

   task automatic t_front();
      wreg(16'h1010, 16'h0054);
      front = 1'b1;
      repeat (6) @(negedge mclk);
      front = 1'b0;
      repeat (4) @(negedge mclk);
      rchk("scope kept", 16'h1010, 16'h0010);
      wreg(16'h1010, 16'h0000);
      drst_n = 0;
      front = 1'b1;
      repeat (8) @(negedge mclk);
      front = 1'b0;
      `CHK("data reset", 1, drst_n)
      wreg(16'h1010, 16'h0010);
      wreg(16'h1004, 16'h0055);
      rchk("chain write", 16'h1004, 16'h0055);
      `CHK("chain out", 8'h55, chain)
      hard_reset();
      rchk("scope hard", 16'h1010, 16'h0000);
      rchk("chain hard", 16'h1004, 16'h00aa);
   endtask : t_front

   initial begin
      repeat (20000) @(posedge mclk);
      failures++;
      tally_and_finish();
   end

   initial begin
      {sys_rst, aux, front, crdy, cbusy, conv, full, mtest} = 8'hff;
      {aux, front, crdy, cbusy, conv, full, mtest} = 7'h00;
      {bstart, bword, trl, last, wide, cdone} = 6'h00;
      slot_lines = 5'h00;
      rotary = 8'hc3;
      evc = 6'h00;
      trig = 5'h00;
      repeat (5) @(negedge mclk);
      sys_rst = 1'b0;
      @(negedge mclk);
      t_reset();
      t_setclr();
      t_slot();
      t_status();
      t_irq();
      t_readout();
      t_front();
      tally_and_finish();
   end
endmodule : vmcsr_top_tb
`default_nettype wire
